// ===== rtl/pdtfr_pkg.sv
package pdtfr_pkg;
    // Register byte offsets on the bus.
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_OPT = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_DTV0 = 8'h0C;
    localparam logic [7:0] OFF_DTV1 = 8'h10;
    localparam logic [7:0] OFF_CMP0 = 8'h14;
    localparam logic [7:0] OFF_CMP_STEP = 8'h04;
    // Control register fields.
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_MODE_LSB = 4;
    // Option register fields.
    localparam int OPT_DT_EN = 0;
    localparam int OPT_RL_THIN_EN = 1;
    localparam int OPT_IRQ_THIN_EN = 2;
    localparam int OPT_RL_THIN_SEL = 3;
    localparam int OPT_THIN_LSB = 8;
    localparam int OPT_PHASE_CHK0 = 16;
    localparam int OPT_PHASE_CHK1 = 17;
    localparam int OPT_OUT1_EN = 18;
    localparam int OPT_OUT2_EN = 19;
    // Status register fields.
    localparam int STAT_OVF = 0;
    localparam int STAT_SIMUL = 1;
    localparam int STAT_CNT_LSB = 16;
    // Reset values.
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] OPT_RESET = 32'h000C_0000;
    localparam logic [15:0] CMP_RESET = 16'h0000;
    localparam logic [15:0] DTV_RESET = 16'h0000;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_TOP = 16'hFFFF;
    // Mode field encodings.
    localparam logic [3:0] MODE_PWM = 4'h4;
    localparam logic [3:0] MODE_FREE = 4'h5;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    typedef enum logic [2:0]
    {
        PDTFR_IDLE = 3'b001,
        PDTFR_PWM = 3'b010,
        PDTFR_FREE = 3'b100
    } pdtfr_mode_t;
endpackage : pdtfr_pkg

// ===== rtl/pdtfr_timer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Both thinnings need three enable bits plus count.
// - Enable set, select clear: interrupt thinning only.
// - Dead-time enable gates outputs one to four.
// - Out1/3 falling uses value 1, else 0.
// - Fall starts counter; partner waits for finish.
// - Partner match before finish keeps it inactive.
// - Pair rising together raises the error.
// - Output 2 full duty masks output 1, errors.
// - Dead-time values take effect at reload, or at once while PWM is off.
// - Thinned reload applies dead time; arm by compare_1.
// - Output 5 is plain PWM, no dead time.
// - PWM: output 0 toggles per cycle, 6 inactive.
// - Error on actual overlap, or set condition.
// - Checking flags set conditions even when disabled.
// - Free-run counts 0000H-FFFFH, overflow flag and pulse.
// - Free-run compare match k pulses its interrupt.
// - Free-run compare writes act at once.
// - Free-run outputs active at start, toggle on match.
// - Overflow flag cleared by writing 0 or stopping.
// - Mode field 0101 selects free-running.
// - Free-run counter never clears on compare.
// - Mode field 0100 selects edge PWM.
// - PWM outputs set at start, clear on duty.
module pdtfr_timer #(
    parameter int CNT_W = 16,
    parameter int THIN_W = 5
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Timer outputs, active high
    output logic [6:0] timer_out,
    // Event pulses
    output logic [5:0] compare_match_irqs,
    output logic overflow_irq,
    output logic error_irq
);
    initial
    begin
        if (CNT_W != 16 || THIN_W < 1 || THIN_W > 8)
        begin
            $error("pdtfr_timer: unsupported parameter values");
        end
    end

    // Bus front end.
    logic wr_pend_q, rd_unused;
    logic [7:0] addr_q;
    logic [31:0] ctrl_q, opt_q, hrdata_q, rdata_d;
    logic [CNT_W-1:0] cmp_q [6];
    logic [CNT_W-1:0] cmpb_q [6];
    logic [CNT_W-1:0] dtv_q [2];
    logic [CNT_W-1:0] dtvb_q [2];
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic run_q, run_prev_q, ovf_q, simul_q, arm_q;
    logic [THIN_W-1:0] thin_q;
    logic [6:0] out_q;
    logic [5:0] cmi_q;
    logic ovi_q, eri_q;

    wire take = hsel & hready & htrans[1];
    assign rd_unused = hsize[0];
    wire wr_ctrl = wr_pend_q && addr_q == pdtfr_pkg::OFF_CTRL;
    wire wr_opt = wr_pend_q && addr_q == pdtfr_pkg::OFF_OPT;
    wire wr_stat = wr_pend_q && addr_q == pdtfr_pkg::OFF_STAT;
    wire wr_dtv0 = wr_pend_q && addr_q == pdtfr_pkg::OFF_DTV0;
    wire wr_dtv1 = wr_pend_q && addr_q == pdtfr_pkg::OFF_DTV1;

    function automatic logic [7:0] cmp_off(input int k);
        cmp_off = pdtfr_pkg::OFF_CMP0 + 8'(k) * pdtfr_pkg::OFF_CMP_STEP;
    endfunction : cmp_off

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_pend_q <= 1'b0;
            addr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            wr_pend_q <= take & hwrite;
            addr_q <= take ? haddr[7:0] : addr_q;
            hrdata_q <= (take & ~hwrite) ? rdata_d : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
    assign hrdata = hrdata_q;

    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (haddr[7:0] == pdtfr_pkg::OFF_CTRL)
            rdata_d = ctrl_q;
        else if (haddr[7:0] == pdtfr_pkg::OFF_OPT)
            rdata_d = opt_q;
        else if (haddr[7:0] == pdtfr_pkg::OFF_STAT)
            rdata_d = {cnt_q, 14'h0000, simul_q, ovf_q};
        else if (haddr[7:0] == pdtfr_pkg::OFF_DTV0)
            rdata_d = {16'h0000, dtv_q[0]};
        else if (haddr[7:0] == pdtfr_pkg::OFF_DTV1)
            rdata_d = {16'h0000, dtv_q[1]};
        else
        begin
            for (int k = 0; k < 6; k++)
            begin
                if (haddr[7:0] == cmp_off(k))
                    rdata_d = {16'h0000, cmp_q[k]};
            end
        end
    end

    // Configuration decode.
    wire [3:0] mode_field = ctrl_q[pdtfr_pkg::CTRL_MODE_LSB +: 4];
    wire is_pwm = mode_field == pdtfr_pkg::MODE_PWM;
    wire is_free = mode_field == pdtfr_pkg::MODE_FREE;
    wire run_bit = ctrl_q[pdtfr_pkg::CTRL_RUN_BIT];
    wire dead_time_enable = opt_q[pdtfr_pkg::OPT_DT_EN];
    wire reload_thin_enable = opt_q[pdtfr_pkg::OPT_RL_THIN_EN];
    wire irq_thin_enable = opt_q[pdtfr_pkg::OPT_IRQ_THIN_EN];
    wire reload_thin_select = opt_q[pdtfr_pkg::OPT_RL_THIN_SEL];
    wire [THIN_W-1:0] thin_count_field = opt_q[pdtfr_pkg::OPT_THIN_LSB +: THIN_W];
    wire phase_check = opt_q[pdtfr_pkg::OPT_PHASE_CHK0] | opt_q[pdtfr_pkg::OPT_PHASE_CHK1];
    wire out1_enable = opt_q[pdtfr_pkg::OPT_OUT1_EN];
    wire out2_enable = opt_q[pdtfr_pkg::OPT_OUT2_EN];
    wire thin_set = thin_count_field != '0;
    wire thin_both = reload_thin_enable & irq_thin_enable & reload_thin_select & thin_set;
    wire thin_irq_only = reload_thin_enable & ~reload_thin_select & thin_set;
    wire thin_point = thin_q == thin_count_field;
    wire check_set = dead_time_enable | phase_check;
    pdtfr_pkg::pdtfr_mode_t mode;
    assign mode = is_pwm ? pdtfr_pkg::PDTFR_PWM :
                  is_free ? pdtfr_pkg::PDTFR_FREE : pdtfr_pkg::PDTFR_IDLE;

    // Counter: PWM clears at the cycle match, free-run only wraps.
    wire pwm_run = run_q & (mode == pdtfr_pkg::PDTFR_PWM);
    wire free_run = run_q & (mode == pdtfr_pkg::PDTFR_FREE);
    wire cyc_match = pwm_run & (cnt_q == cmpb_q[0]);
    wire wrap = free_run & (cnt_q == pdtfr_pkg::CNT_TOP);
    wire started = run_q & ~run_prev_q;
    // Reloads with thinning wait for a compare_1 write, then the thinned cycle.
    wire reload = cyc_match & (~reload_thin_enable | arm_q) & (~thin_both | thin_point);
    wire cc0_ok = ~(thin_both | thin_irq_only) | thin_point;
    assign cnt_d = ~run_q ? pdtfr_pkg::CNT_ZERO :
                   cyc_match ? pdtfr_pkg::CNT_ZERO : cnt_q + 16'h0001;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q <= pdtfr_pkg::CTRL_RESET;
            opt_q <= pdtfr_pkg::OPT_RESET;
            run_q <= 1'b0;
            run_prev_q <= 1'b0;
            cnt_q <= pdtfr_pkg::CNT_ZERO;
            thin_q <= '0;
            arm_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= wr_ctrl ? hwdata : ctrl_q;
            opt_q <= wr_opt ? hwdata : opt_q;
            run_q <= run_bit;
            run_prev_q <= run_q;
            cnt_q <= cnt_d;
            thin_q <= ~cyc_match ? thin_q : (thin_point ? '0 : thin_q + 1'b1);
            // A compare_1 write arms the next reload; the write wins over the clear.
            arm_q <= (wr_pend_q && addr_q == cmp_off(1)) | (arm_q & ~reload);
        end
    end

    // Compare registers and their reload buffers.
    genvar g;
    generate
        for (g = 0; g < 6; g++)
        begin : g_cmp
            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    cmp_q[g] <= pdtfr_pkg::CMP_RESET;
                    cmpb_q[g] <= pdtfr_pkg::CMP_RESET;
                end
                else
                begin
                    cmp_q[g] <= (wr_pend_q && addr_q == cmp_off(g)) ? hwdata[15:0] : cmp_q[g];
                    // Free-run compares are used straight from the register.
                    cmpb_q[g] <= (~pwm_run | reload) ? cmp_q[g] : cmpb_q[g];
                end
            end
        end
    endgenerate

    // Dead-time values move into the working copy at a reload, or every cycle while PWM is not running.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dtv_q[0] <= pdtfr_pkg::DTV_RESET;
            dtv_q[1] <= pdtfr_pkg::DTV_RESET;
            dtvb_q[0] <= pdtfr_pkg::DTV_RESET;
            dtvb_q[1] <= pdtfr_pkg::DTV_RESET;
        end
        else
        begin
            dtv_q[0] <= wr_dtv0 ? hwdata[15:0] : dtv_q[0];
            dtv_q[1] <= wr_dtv1 ? hwdata[15:0] : dtv_q[1];
            dtvb_q[0] <= (~pwm_run | reload) ? dtv_q[0] : dtvb_q[0];
            dtvb_q[1] <= (~pwm_run | reload) ? dtv_q[1] : dtvb_q[1];
        end
    end

    // PWM demand levels before dead time, from the buffered compares.
    logic [5:1] raw, raw_q, lvl;
    logic [CNT_W-1:0] dt_cnt_q [2];
    logic [1:0] dt_tgt_b_q;
    logic [1:0] dt_busy, set_both, act_both;
    generate
        for (g = 1; g <= 5; g++)
        begin : g_raw
            assign raw[g] = pwm_run & (cnt_q < cmpb_q[g]);
        end
        for (g = 0; g < 2; g++)
        begin : g_pair
            localparam int A = 2 * g + 1;
            localparam int B = 2 * g + 2;
            assign dt_busy[g] = dead_time_enable & (dt_cnt_q[g] != '0);
            // The count and an active mate only hold off a rise; a pin already on is not cut.
            // On a tie the odd pin wins, so with dead time enabled the pair never goes active together.
            assign lvl[A] = raw[A] & (out_q[A] | ~(dt_busy[g] & ~dt_tgt_b_q[g]) &
                            ~(dead_time_enable & out_q[B]));
            assign lvl[B] = raw[B] & (out_q[B] | ~(dt_busy[g] & dt_tgt_b_q[g]) &
                            ~(dead_time_enable & (out_q[A] | lvl[A])));
            assign set_both[g] = raw[A] & raw[B] & ~(raw_q[A] & raw_q[B]);
            assign act_both[g] = out_q[A] & out_q[B];
            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    dt_cnt_q[g] <= '0;
                    dt_tgt_b_q[g] <= 1'b0;
                end
                else if (raw_q[A] & ~raw[A] & dead_time_enable)
                begin
                    dt_cnt_q[g] <= dtvb_q[1];
                    dt_tgt_b_q[g] <= 1'b1;
                end
                else if (raw_q[B] & ~raw[B] & dead_time_enable)
                begin
                    dt_cnt_q[g] <= dtvb_q[0];
                    dt_tgt_b_q[g] <= 1'b0;
                end
                else if (dt_cnt_q[g] != '0)
                begin
                    dt_cnt_q[g] <= dt_cnt_q[g] - 16'h0001;
                end
            end
        end
    endgenerate
    assign lvl[5] = raw[5];

    // Error detection differs with the set-condition check on or off.
    wire err_ev = run_q & is_pwm & (check_set ? |set_both : |act_both);
    wire stat_clr_ovf = wr_stat & ~hwdata[pdtfr_pkg::STAT_OVF];
    wire stat_clr_sim = wr_stat & ~hwdata[pdtfr_pkg::STAT_SIMUL];
    logic [5:0] fr_match;
    generate
        for (g = 0; g < 6; g++)
        begin : g_fm
            assign fr_match[g] = free_run & (cnt_q == cmp_q[g]);
        end
    endgenerate
    wire [5:0] pwm_match = {raw_q[5:1] & ~raw[5:1] | {5{1'b0}}, cyc_match & cc0_ok};
    wire [6:0] pwm_out = {1'b0, lvl[5], lvl[4], lvl[3], lvl[2] & out2_enable,
                          lvl[1] & out1_enable, out_q[0] ^ cyc_match};
    wire [6:0] free_out = started ? 7'h3F : {1'b0, out_q[5:0] ^ fr_match};

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            raw_q <= 5'h00;
            out_q <= 7'h00;
            cmi_q <= 6'h00;
            ovi_q <= 1'b0;
            eri_q <= 1'b0;
            ovf_q <= 1'b0;
            simul_q <= 1'b0;
        end
        else
        begin
            raw_q <= raw;
            out_q <= ~run_q ? 7'h00 : (pwm_run ? (started ? {6'h00, 1'b1} | pwm_out : pwm_out) :
                     (free_run ? free_out : 7'h00));
            cmi_q <= pwm_run ? pwm_match : fr_match;
            ovi_q <= wrap;
            eri_q <= err_ev;
            // Hardware set beats a software clear landing in the same cycle.
            ovf_q <= wrap | (ovf_q & ~stat_clr_ovf & run_q);
            simul_q <= err_ev | (simul_q & ~stat_clr_sim);
        end
    end
    assign timer_out = out_q;
    assign compare_match_irqs = cmi_q;
    assign overflow_irq = ovi_q;
    assign error_irq = eri_q;

    sequence start_s;
        !run_q ##1 run_q;
    endsequence

    ovf_flag_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wrap |=> ovf_q && overflow_irq)
        else $error("overflow did not set flag and pulse");
    ovf_flag_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ovf_q && run_q && !stat_clr_ovf |=> ovf_q)
        else $error("overflow flag lost without clear");
    ovf_stop_clr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !run_q && !wrap |=> !ovf_q)
        else $error("overflow flag survived stop");
    pwm_wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cyc_match |=> cnt_q == pdtfr_pkg::CNT_ZERO && timer_out[0] != $past(timer_out[0]))
        else $error("cycle match did not clear counter and toggle");
    fr_cmp_irq_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        free_run && cnt_q == cmp_q[1] |=> compare_match_irqs[1])
        else $error("free-run compare pulse missing");
    fr_start_out_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        start_s ##0 is_free |=> timer_out[5:0] == 6'h3F)
        else $error("free-run outputs not active at start");
    dt_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        dead_time_enable && raw_q[1] && !raw[1] |=> dt_cnt_q[0] == $past(dtvb_q[1]))
        else $error("dead time after output 1 fall wrong");
    dt_block_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        dt_busy[0] && dt_tgt_b_q[0] && !timer_out[2] |=> !timer_out[2])
        else $error("output 2 rose during dead time");
    full_duty_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        dead_time_enable && out_q[2] |=> !timer_out[1])
        else $error("output 1 active while output 2 held");
    err_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        run_q && is_pwm && check_set && |set_both |=> error_irq && simul_q)
        else $error("set condition not flagged");
endmodule : pdtfr_timer

// ===== testbench/pdtfr_load_model.sv
`timescale 1ns/1ps
// The loads only sense the pins and never drive back, so they cannot hide a timer fault.
module pdtfr_load_model (
    // Clock and measuring window
    input wire logic ref_clk,
    input wire logic clr,
    input wire logic win,
    // Timer pins seen by the loads
    input wire logic [6:0] load_in,
    // Figures gathered in the window
    output int hi [7],
    output int rise0,
    output int both12
);
    logic prev0 = 1'b0;

    always @(posedge ref_clk)
    begin
        prev0 <= load_in[0];
        if (clr)
        begin
            hi <= '{default: 0};
            rise0 <= 0;
            both12 <= 0;
        end
        else if (win)
        begin
            for (int k = 0; k < 7; k++)
                hi[k] <= hi[k] + int'(load_in[k] === 1'b1);
            rise0 <= rise0 + int'(load_in[0] === 1'b1 && prev0 === 1'b0);
            both12 <= both12 + int'(load_in[1] === 1'b1 && load_in[2] === 1'b1);
        end
    end
endmodule : pdtfr_load_model

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module testbench;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, win = 1'b0, clr = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, overflow_irq, error_irq;
    logic [6:0] timer_out;
    logic [5:0] compare_match_irqs;
    int n_errors = 0, checks_done = 0, err_cnt = 0, ovf_cnt = 0, t;
    int cm_cnt [6];
    int hi [7];
    int rise0, both12;
    int exp_hi [7] = '{50, 30, 50, 20, 70, 60, 0};
    localparam logic [31:0] OPT_B = 32'h000C_0000;

    always #5 ref_clk = ~ref_clk;

    pdtfr_timer pdtfr_timer_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer_out(timer_out),
        .compare_match_irqs(compare_match_irqs), .overflow_irq(overflow_irq),
        .error_irq(error_irq)
    );
    pdtfr_load_model pdtfr_load_model_inst (
        .ref_clk(ref_clk), .clr(clr), .win(win), .load_in(timer_out), .hi(hi),
        .rise0(rise0), .both12(both12)
    );

    // Event pulses are counted in the same window as the load figures.
    always @(posedge ref_clk)
    begin
        if (clr)
        begin
            err_cnt <= 0;
            ovf_cnt <= 0;
            cm_cnt <= '{default: 0};
        end
        else if (win)
        begin
            err_cnt <= err_cnt + int'(error_irq === 1'b1);
            ovf_cnt <= ovf_cnt + int'(overflow_irq === 1'b1);
            for (int k = 0; k < 6; k++)
                cm_cnt[k] <= cm_cnt[k] + int'(compare_match_irqs[k] === 1'b1);
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic edge_rdy();
        int n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            n_errors++;
            tally_and_finish();
        end
    endtask : edge_rdy

    task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= pdtfr_pkg::HTRANS_NONSEQ;
        hwrite <= wr_en;
        edge_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        edge_rdy();
        q = hrdata;
        `CHK("okay response", 1'b0, hresp)
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        `CHK(nm, e, q & m)
    endtask : rd

    // Compares change only while stopped, so the buffers follow without a reload.
    task automatic pwm(input logic [31:0] opt, input logic [15:0] c [6]);
        wr(pdtfr_pkg::OFF_CTRL, 32'h0000_0040);
        wr(pdtfr_pkg::OFF_OPT, opt);
        for (int k = 0; k < 6; k++)
            wr(8'(pdtfr_pkg::OFF_CMP0 + pdtfr_pkg::OFF_CMP_STEP * k), {16'h0, c[k]});
        wr(pdtfr_pkg::OFF_STAT, 32'h0);
        wr(pdtfr_pkg::OFF_CTRL, 32'h0000_0041);
        repeat (30) @(posedge ref_clk);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        win <= 1'b1;
        repeat (100) @(posedge ref_clk);
        win <= 1'b0;
        @(posedge ref_clk);
    endtask : pwm

    initial
    begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd("ctrl reset", pdtfr_pkg::OFF_CTRL, 32'hFFFF_FFFF, pdtfr_pkg::CTRL_RESET);
        rd("opt reset", pdtfr_pkg::OFF_OPT, 32'hFFFF_FFFF, pdtfr_pkg::OPT_RESET);
        rd("stat reset", pdtfr_pkg::OFF_STAT, 32'h0000_FFFF, 32'h0);
        rd("cmp0 reset", pdtfr_pkg::OFF_CMP0, 32'hFFFF_FFFF, 32'h0);
        wr(8'hFC, 32'hFFFF_FFFF);
        rd("unmapped", 8'hFC, 32'hFFFF_FFFF, 32'h0);
        wr(pdtfr_pkg::OFF_DTV0, 32'hABCD_0002);
        rd("dead time 0", pdtfr_pkg::OFF_DTV0, 32'hFFFF_FFFF, 32'h2);
        wr(pdtfr_pkg::OFF_DTV1, 32'h0000_0004);
        pwm(OPT_B, '{16'h9, 16'h3, 16'h5, 16'h2, 16'h7, 16'h6});
        for (int k = 0; k < 7; k++)
            `CHK("pin high cycles", exp_hi[k], hi[k])
        `CHK("cycle toggles", 5, rise0)
        `CHK("overlap error", 30, err_cnt)
        `CHK("cycle irqs", 10, cm_cnt[0])
        rd("simul flag", pdtfr_pkg::OFF_STAT, 32'h2, 32'h2);
        for (int i = 0; i < 2; i++)
        begin
            pwm(OPT_B | 32'h100 | (i == 0 ? 32'hE : 32'h2), '{16'h9, 16'h3, 16'h5, 16'h2, 16'h7, 16'h6});
            `CHK("thinned irqs", 5, cm_cnt[0])
        end
        // No gap after output 2 falls, so output 1 wins the tie at each cycle start.
        wr(pdtfr_pkg::OFF_DTV0, 32'h0000_0000);
        pwm(OPT_B | 32'h1, '{16'h9, 16'h2, 16'h8, 16'h0, 16'h0, 16'h6});
        `CHK("pair overlap", 0, both12)
        `CHK("out1 short gap", 20, hi[1])
        `CHK("out2 late rise", 1'b1, hi[2] inside {[10:30]})
        `CHK("out5 plain", 60, hi[5])
        `CHK("clash pulses", 10, err_cnt)
        pwm(OPT_B | 32'h1, '{16'h9, 16'h8, 16'h2, 16'h0, 16'h0, 16'h0});
        `CHK("out2 kept low", 0, hi[2])
        pwm(OPT_B | 32'h1, '{16'h9, 16'h3, 16'hA, 16'h0, 16'h0, 16'h0});
        `CHK("out1 masked", 0, hi[1])
        `CHK("out2 full", 100, hi[2])
        `CHK("full duty error", 1'b1, err_cnt > 0)
        for (int i = 0; i < 2; i++)
        begin
            pwm(32'h1 << (16 + i), '{16'h9, 16'h3, 16'h5, 16'h0, 16'h0, 16'h0});
            `CHK("disabled pins low", 0, hi[1] + hi[2])
            `CHK("disabled pins error", 10, err_cnt)
            rd("disabled simul", pdtfr_pkg::OFF_STAT, 32'h2, 32'h2);
        end
        pwm(32'h0, '{16'h9, 16'h3, 16'h5, 16'h0, 16'h0, 16'h0});
        `CHK("checks silenced", 0, err_cnt)
        wr(pdtfr_pkg::OFF_CTRL, 32'h0000_0040);
        for (int k = 0; k < 6; k++)
            wr(8'(pdtfr_pkg::OFF_CMP0 + pdtfr_pkg::OFF_CMP_STEP * k), 32'h1000 * (k + 1));
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        win <= 1'b1;
        wr(pdtfr_pkg::OFF_CTRL, 32'h0000_0051);
        repeat (4) @(posedge ref_clk);
        `CHK("free start pins", 6'h3F, timer_out[5:0])
        wr(8'(pdtfr_pkg::OFF_CMP0 + pdtfr_pkg::OFF_CMP_STEP * 5), 32'h0800);
        repeat (3000) @(posedge ref_clk);
        `CHK("instant compare", 6'h1F, timer_out[5:0])
        t = 0;
        while (overflow_irq !== 1'b1 && t < 70000)
        begin
            @(posedge ref_clk);
            t++;
        end
        win <= 1'b0;
        if (t >= 70000)
        begin
            n_errors++;
            tally_and_finish();
        end
        repeat (2) @(posedge ref_clk);
        for (int k = 0; k < 6; k++)
            `CHK("match irqs", 1, cm_cnt[k])
        `CHK("overflow pulses", 1, ovf_cnt)
        `CHK("pins after wrap", 6'h00, timer_out[5:0])
        rd("overflow flag", pdtfr_pkg::OFF_STAT, 32'h1, 32'h1);
        rd("flag kept on read", pdtfr_pkg::OFF_STAT, 32'h1, 32'h1);
        wr(pdtfr_pkg::OFF_STAT, 32'h1);
        rd("flag kept on one", pdtfr_pkg::OFF_STAT, 32'h1, 32'h1);
        wr(pdtfr_pkg::OFF_STAT, 32'h0);
        rd("flag cleared", pdtfr_pkg::OFF_STAT, 32'h1, 32'h0);
        tally_and_finish();
    end
endmodule : testbench
